/* design/tcr_pkg.sv */
// Package: register map, field positions, reset values and phase timing of the timer
package tcr_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_CONTROL   = 8'hC8;
    localparam logic [7:0] IDX_MODE      = 8'hC9;
    localparam logic [7:0] IDX_CAP_LOW   = 8'hCA;
    localparam logic [7:0] IDX_CAP_HIGH  = 8'hCB;
    localparam logic [7:0] IDX_CNT_LOW   = 8'hCC;
    localparam logic [7:0] IDX_CNT_HIGH  = 8'hCD;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_EXTERNAL_FLAG = 6;
    localparam int BIT_RX_CLK_EN     = 5;
    localparam int BIT_TX_CLK_EN     = 4;
    localparam int BIT_EXT_EN        = 3;
    localparam int BIT_RUN           = 2;
    localparam int BIT_COUNTER_SEL   = 1;
    localparam int BIT_CAPTURE_SEL   = 0;

    // Mode register fields
    localparam int BIT_OUTPUT_EN     = 1;
    localparam int BIT_DOWN_COUNT_EN = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [1:0]  RST_MODE    = 2'h0;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;

    // ************************************************************
    // Machine cycle timing: 6 states of 2 phases, clock is the oscillator
    // ************************************************************
    localparam int         OSC_PER_MACHINE = 12;
    localparam logic [3:0] PHASE_LAST      = 4'(OSC_PER_MACHINE - 1);
    localparam logic [3:0] SAMPLE_PHASE    = 4'h9;  // State 5, phase 2
    localparam logic [3:0] UPDATE_PHASE    = 4'h4;  // State 3, phase 1

    // Operating modes decoded from the control bits
    typedef enum logic [3:0] {
        TCR_OFF     = 4'b0001,
        TCR_RELOAD  = 4'b0010,
        TCR_CAPTURE = 4'b0100,
        TCR_BAUD    = 4'b1000
    } tcr_mode_e;

endpackage

/* design/tcr_timer.sv */
// Timer three: 16-bit capture/reload timer/counter with Avalon-MM register access
`timescale 1ns/10ps
//
// Behaviour
// [RULE_01] Control register resets to all zeros
// [RULE_02] Overflow sets bit 7; only software clears
// [RULE_03] No overflow flag while serial clocking
// [RULE_04] Trigger capture/reload sets external flag bit 6
// [RULE_05] External flag requests interrupt unless down-count
// [RULE_06] Bit 5 routes overflow pulses to receiver
// [RULE_07] Bit 4 routes overflow pulses to transmitter
// [RULE_08] Bit 3 enables trigger falling edge events
// [RULE_09] Bit 2 starts and stops counting
// [RULE_10] Bit 1 selects timer or event counting
// [RULE_11] Bit 0 selects capture or reload
// [RULE_12] Serial clocking forces reload on overflow
// [RULE_13] Mode decoded: reload, capture, baud, off
// [RULE_14] Count held as low and high bytes
// [RULE_15] Timer increments once per twelve clocks
// [RULE_16] Count input sampled once per machine cycle
// [RULE_17] Counted edge appears at update phase
// [RULE_18] Source holds each level one machine cycle
// [RULE_19] Capture without trigger: plain overflowing counter
// [RULE_20] Capture copies count bytes, sets external flag
// [RULE_21] Down-count enable bit, resets to zero
// [RULE_22] Interrupt is OR of both flags
// [RULE_23] Machine cycle of six two-phase states
module tcr_timer
    import tcr_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Port pins
    input  wire logic        event_count_input,
    input  wire logic        trigger_input,
    // Interrupt request and serial port clocks
    output logic             timer_irq,
    output logic             serial_rx_clock,
    output logic             serial_tx_clock
);

    // ************************************************************
    // State
    // ************************************************************
    // Field order is free; nothing outside
    // reads the packed layout.
    // Phase counts 0 to 11 within a
    // machine cycle.
    typedef struct packed {
        logic        waitreq;
        logic [31:0] readdata;
        logic [7:0]  control;
        logic [1:0]  mode;
        logic [7:0]  cap_low;
        logic [7:0]  cap_high;
        logic [7:0]  cnt_low;
        logic [7:0]  cnt_high;
        logic [3:0]  phase;
        logic        ev_meta;
        logic        ev_sync;
        logic        ev_sample;
        logic        ev_pend;
        logic        tr_meta;
        logic        tr_sync;
        logic        tr_sample;
        logic        tr_pend;
        logic        irq;
        logic        rx_pulse;
        logic        tx_pulse;
    } tcr_state_s;

    // All state lives in one register;
    // next_st is its combinational copy.
    // Reset clears every field except
    // waitrequest, which idles high.
    // Nothing else in the block holds
    // a value from one edge to the next.

    tcr_state_s st;
    tcr_state_s next_st;

    // Each register owns one 32-bit word;
    // byte lanes above the first read zero.
    // A misaligned address matches nothing.

    // Register index match on a word-aligned byte address
    function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
        reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // Run bit off wins over everything;
    // a serial clock enable wins over the
    // capture select, which then is ignored.
    // Mode decode from control bits
    function automatic tcr_mode_e decode_mode(input logic [7:0] ctl);
        if (!ctl[BIT_RUN]) begin
            decode_mode = TCR_OFF;
        end else if (ctl[BIT_RX_CLK_EN] || ctl[BIT_TX_CLK_EN]) begin
            decode_mode = TCR_BAUD;
        end else if (ctl[BIT_CAPTURE_SEL]) begin
            decode_mode = TCR_CAPTURE;
        end else begin
            decode_mode = TCR_RELOAD;
        end
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic        baud;
        logic        down_mode;
        logic        at_sample;
        logic        at_update;
        logic        state_end;
        logic        tick;
        logic        overflow;
        logic        underflow;
        logic        trig_event;
        logic        set_ovf;
        logic        set_ext;
        logic        tog_ext;
        logic        wr_go;
        logic [15:0] count;
        logic [15:0] reload;
        tcr_mode_e   md;

        // Start from the held state; every
        // branch below only overrides what
        // changes, so no latch can form.
        next_st    = st;
        md         = decode_mode(st.control);                                   // [RULE_13]
        baud       = st.control[BIT_RX_CLK_EN] | st.control[BIT_TX_CLK_EN];
        down_mode  = st.mode[BIT_DOWN_COUNT_EN] && (md == TCR_RELOAD);           // [RULE_21]
        count      = {st.cnt_high, st.cnt_low};                                 // [RULE_14]
        reload     = {st.cap_high, st.cap_low};
        set_ovf    = 1'b0;
        set_ext    = 1'b0;
        tog_ext    = 1'b0;
        overflow   = 1'b0;
        underflow  = 1'b0;
        trig_event = 1'b0;

        // The clock stands in for the
        // oscillator. Phase 0 is the first
        // half of state one; odd phases end
        // a state time.

        // Machine cycle phase counter, twelve clocks per cycle
        next_st.phase = (st.phase == PHASE_LAST) ? 4'h0 : st.phase + 4'h1;     // [RULE_23]
        at_sample     = (st.phase == SAMPLE_PHASE);
        at_update     = (st.phase == UPDATE_PHASE);
        state_end     = st.phase[0];                                             // [RULE_23]

        // Both pins come from outside the
        // clock domain; only the second
        // flip-flop of each pair is read.

        // Pin synchronisers
        next_st.ev_meta = event_count_input;
        next_st.ev_sync = st.ev_meta;
        next_st.tr_meta = trigger_input;
        next_st.tr_sync = st.tr_meta;

        // One sample per machine cycle, so a
        // level shorter than twelve clocks
        // may be missed entirely. The edge
        // waits in a pending bit for the
        // update phase.

        // Sample pins once per machine cycle, remember a falling edge
        if (at_sample) begin
            next_st.ev_sample = st.ev_sync;                                      // [RULE_16]
            next_st.tr_sample = st.tr_sync;
            if (st.ev_sample && !st.ev_sync) begin
                next_st.ev_pend = 1'b1;                                          // [RULE_16]
            end
            if (st.tr_sample && !st.tr_sync) begin
                next_st.tr_pend = 1'b1;
            end
        end

        // Only one tick source is live at a
        // time; the run bit gates them all.

        // Count tick: edge count, state time in baud mode, else machine cycle
        if (md == TCR_OFF) begin
            tick = 1'b0;                                                         // [RULE_09]
        end else if (st.control[BIT_COUNTER_SEL]) begin
            tick = st.ev_pend && at_update;                                      // [RULE_10] [RULE_17]
        end else if (baud) begin
            tick = state_end;
        end else begin
            tick = at_update;                                                    // [RULE_15]
        end
        if (at_update) begin
            next_st.ev_pend = 1'b0;
        end

        // Down counting needs reload mode and
        // the down-count enable; the trigger
        // pin level then picks the direction.
        // Underflow happens when the count
        // meets the capture/reload pair.

        // Counting, overflow and underflow
        if (tick) begin
            if (down_mode && !st.tr_sample) begin
                if (count == reload) begin
                    underflow = 1'b1;
                    count     = CNT_ALL_ONE;
                end else begin
                    count = count - 16'h0001;
                end
            end else if (count == CNT_ALL_ONE) begin
                overflow = 1'b1;
                count    = (md == TCR_CAPTURE) ? 16'h0000 : reload;             // [RULE_11] [RULE_12]
            end else begin
                count = count + 16'h0001;
            end
        end
        if ((overflow || underflow) && !baud) begin
            set_ovf = 1'b1;                                                      // [RULE_02] [RULE_03] [RULE_19]
        end
        if (down_mode && (overflow || underflow)) begin
            tog_ext = 1'b1;
        end

        // A pending trigger edge is dropped at
        // every update phase, so a trigger
        // seen while disabled never fires
        // later when the enable is set.

        // Trigger events at the update phase
        if (at_update) begin
            next_st.tr_pend = 1'b0;
            trig_event = st.tr_pend && st.control[BIT_EXT_EN] && (md != TCR_OFF)
                         && !down_mode;                                          // [RULE_08]
        end
        if (trig_event) begin
            set_ext = 1'b1;                                                      // [RULE_04]
            if (md == TCR_CAPTURE) begin
                next_st.cap_high = count[15:8];                                  // [RULE_20]
                next_st.cap_low  = count[7:0];                                   // [RULE_20]
            end else if (md == TCR_RELOAD) begin
                count = reload;                                                  // [RULE_11]
            end
        end
        next_st.cnt_high = count[15:8];
        next_st.cnt_low  = count[7:0];

        // One-cycle pulses; the serial port
        // divides them further on its side.

        // Overflow pulses routed to the serial port
        next_st.rx_pulse = overflow && st.control[BIT_RX_CLK_EN];               // [RULE_06]
        next_st.tx_pulse = overflow && st.control[BIT_TX_CLK_EN];               // [RULE_07]

        // Every access takes two cycles: the
        // first edge loads read data and drops
        // waitrequest, the second completes.
        // Read data is zero outside the answer
        // cycle, so a stale value never shows.

        // Bus: request answered one cycle after it is first seen
        wr_go           = avs_write && !st.waitreq && avs_byteenable[0];
        next_st.waitreq = !((avs_read || avs_write) && st.waitreq);
        if (avs_read && st.waitreq) begin
            next_st.readdata = 32'h0000_0000;
            if (reg_hit(avs_address, IDX_CONTROL)) begin
                next_st.readdata[7:0] = st.control;
            end else if (reg_hit(avs_address, IDX_MODE)) begin
                next_st.readdata[1:0] = st.mode;
            end else if (reg_hit(avs_address, IDX_CAP_LOW)) begin
                next_st.readdata[7:0] = st.cap_low;
            end else if (reg_hit(avs_address, IDX_CAP_HIGH)) begin
                next_st.readdata[7:0] = st.cap_high;
            end else if (reg_hit(avs_address, IDX_CNT_LOW)) begin
                next_st.readdata[7:0] = st.cnt_low;
            end else if (reg_hit(avs_address, IDX_CNT_HIGH)) begin
                next_st.readdata[7:0] = st.cnt_high;
            end
        end
        // The answer cycle ends at this edge
        // whether or not the master lingers
        if (!st.waitreq) begin
            next_st.readdata = 32'h0000_0000;
        end

        // Writes land only in the answer
        // cycle. A write to the count bytes
        // wins over a tick in the same cycle;
        // stop the timer first to avoid that.

        // Software writes; flags set by hardware win over a clearing write
        if (wr_go && reg_hit(avs_address, IDX_CONTROL)) begin
            next_st.control = avs_writedata[7:0];
        end
        if (wr_go && reg_hit(avs_address, IDX_MODE)) begin
            next_st.mode = avs_writedata[1:0];
        end
        if (wr_go && reg_hit(avs_address, IDX_CAP_LOW)) begin
            next_st.cap_low = avs_writedata[7:0];
        end
        if (wr_go && reg_hit(avs_address, IDX_CAP_HIGH)) begin
            next_st.cap_high = avs_writedata[7:0];
        end
        if (wr_go && reg_hit(avs_address, IDX_CNT_LOW)) begin
            next_st.cnt_low = avs_writedata[7:0];
        end
        if (wr_go && reg_hit(avs_address, IDX_CNT_HIGH)) begin
            next_st.cnt_high = avs_writedata[7:0];
        end
        if (set_ovf) begin
            next_st.control[BIT_OVERFLOW_FLAG] = 1'b1;                           // [RULE_02]
        end
        if (tog_ext) begin
            next_st.control[BIT_EXTERNAL_FLAG] = ~st.control[BIT_EXTERNAL_FLAG];
        end
        if (set_ext) begin
            next_st.control[BIT_EXTERNAL_FLAG] = 1'b1;                           // [RULE_04]
        end

        // Computed from next_st so the request
        // rises on the same edge as its flag.
        // Interrupt request from the flags as they will stand
        next_st.irq = next_st.control[BIT_OVERFLOW_FLAG]
                      || (next_st.control[BIT_EXTERNAL_FLAG]
                          && !next_st.mode[BIT_DOWN_COUNT_EN]);                  // [RULE_05] [RULE_22]
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Asynchronous clear, constants only.
    // Release is seen at the next edge.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st           <= '0;
            st.waitreq   <= 1'b1;
            st.control   <= RST_CONTROL;                                         // [RULE_01]
            st.mode      <= RST_MODE;                                            // [RULE_21]
            st.cap_low   <= RST_BYTE;
            st.cap_high  <= RST_BYTE;
            st.cnt_low   <= RST_BYTE;
            st.cnt_high  <= RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // No logic after the flip-flops: every
    // output is a plain state field.
    // Outputs straight from the state register
    assign avs_readdata    = st.readdata;
    assign avs_waitrequest = st.waitreq;
    assign timer_irq       = st.irq;
    assign serial_rx_clock = st.rx_pulse;
    assign serial_tx_clock = st.tx_pulse;

    // Reads of the count while the timer
    // runs in baud mode may catch a byte
    // mid-carry; no latching is provided.

endmodule

/* verif/tcr_timer_asserts.sv */
// Checker: bus handshake, serial pulse and interrupt relations of timer three
`timescale 1ns/10ps
module tcr_timer_asserts
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // Register bus
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins and outputs
    input wire logic        event_count_input,
    input wire logic        trigger_input,
    input wire logic        timer_irq,
    input wire logic        serial_rx_clock,
    input wire logic        serial_tx_clock
);
    // ************************************************************
    // Properties on the main clock, quiet during reset
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_wait_one_cycle: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after a request");
    a_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_has_cause: assert property (
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    a_idle_data_zero: assert property (
        avs_waitrequest |-> avs_readdata == 32'h0000_0000)
        else $error("read data not zero outside an answer");
    a_data_byte_wide: assert property (
        avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_irq_sw_clear: assert property (
        $fell(timer_irq) |-> $past(avs_write))
        else $error("interrupt dropped without a software write");
    a_rx_pulse_single: assert property (
        serial_rx_clock |=> !serial_rx_clock)
        else $error("receive clock pulse longer than one cycle");
    a_tx_pulse_single: assert property (
        serial_tx_clock |=> !serial_tx_clock)
        else $error("transmit clock pulse longer than one cycle");

    // Main scenarios reached
    c_rx_pulse: cover property (serial_rx_clock && serial_tx_clock);
    c_irq_clear: cover property ($fell(timer_irq));
    c_read_answer: cover property (avs_read && !avs_waitrequest);
endmodule

bind tcr_timer tcr_timer_asserts u_asserts (
    .clock, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .event_count_input,
    .trigger_input, .timer_irq, .serial_rx_clock, .serial_tx_clock
);

/* verif/tcr_pin_model.sv */
// Pin model: external count source and trigger source for timer three
`timescale 1ns/10ps
module tcr_pin_model (
    // Clock
    input wire logic clock,
    // Port pins, pulled up when idle
    output logic     event_count_input,
    output logic     trigger_input
);
    // ************************************************************
    // Pin drivers, each level held a full machine cycle
    // ************************************************************
    initial begin
        event_count_input = 1'b1;
        trigger_input     = 1'b1;
    end

    // Falling edges on the count pin, 25 clocks apart, then settle
    task automatic count_edges(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock) event_count_input <= 1'b0;
            repeat (12) @(posedge clock);
            event_count_input <= 1'b1;
            repeat (12) @(posedge clock);
        end
        repeat (24) @(posedge clock);
    endtask

    // One falling edge on the trigger pin, then settle
    task automatic trigger_fall();
        @(posedge clock) trigger_input <= 1'b0;
        repeat (12) @(posedge clock);
        trigger_input <= 1'b1;
        repeat (36) @(posedge clock);
    endtask
endmodule

/* verif/test_tcr_timer.sv */
// Testbench: registers, timing, capture, reload and serial clocking of timer three
`timescale 1ns/10ps
module test_tcr_timer
    import tcr_pkg::*;
;
    logic        clock, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        event_count_input, trigger_input;
    logic        timer_irq, serial_rx_clock, serial_tx_clock;
    int          mismatches, samples_checked, n;

    // ************************************************************
    // Clock, design and pin model
    // ************************************************************
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    tcr_timer dut (
        .clock, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .event_count_input,
        .trigger_input, .timer_irq, .serial_rx_clock, .serial_tx_clock
    );
    tcr_pin_model pins (.clock, .event_count_input, .trigger_input);

    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus cycles: hold request until waitrequest sampled low
    task automatic bus_cycle(input logic wr, input logic [7:0] idx, input logic [7:0] data);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, data};
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
    endtask
    task automatic bus_write(input logic [7:0] idx, input logic [7:0] data);
        bus_cycle(1'b1, idx, data);
        @(posedge clock);
    endtask
    task automatic expect_reg(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus_cycle(1'b0, idx, 8'h00);
        check(what, {24'h00_0000, exp}, avs_readdata);
        @(posedge clock);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_values();
        expect_reg("control", IDX_CONTROL, 8'h00);
        expect_reg("mode", IDX_MODE, 8'h00);
        bus_write(8'hCE, 8'hFF);
        expect_reg("unmapped", 8'hCE, 8'h00);
        bus_write(IDX_CNT_LOW, 8'hA5);
        repeat (30) @(posedge clock);
        expect_reg("stopped count", IDX_CNT_LOW, 8'hA5);
    endtask

    task automatic t_timer_overflow();
        bus_write(IDX_CAP_LOW, 8'h34);
        bus_write(IDX_CAP_HIGH, 8'h12);
        bus_write(IDX_CNT_LOW, 8'hFE);
        bus_write(IDX_CNT_HIGH, 8'hFF);
        bus_write(IDX_CONTROL, 8'h04);
        n = 0;
        while (timer_irq !== 1'b1) begin
            @(posedge clock);
            n++;
        end
        check("overflow delay", 1, n > 10 && n < 26);
        bus_write(IDX_CONTROL, 8'h80);
        expect_reg("reload low", IDX_CNT_LOW, 8'h34);
        expect_reg("reload high", IDX_CNT_HIGH, 8'h12);
        expect_reg("overflow flag", IDX_CONTROL, 8'h80);
        bus_write(IDX_CONTROL, 8'h00);
        check("irq cleared", 0, timer_irq);
    endtask

    task automatic t_capture();
        bus_write(IDX_CNT_LOW, 8'hC3);
        bus_write(IDX_CNT_HIGH, 8'h5A);
        bus_write(IDX_CONTROL, 8'h0F);
        pins.trigger_fall();
        expect_reg("captured low", IDX_CAP_LOW, 8'hC3);
        expect_reg("captured high", IDX_CAP_HIGH, 8'h5A);
        expect_reg("external flag", IDX_CONTROL, 8'h4F);
        check("irq external", 1, timer_irq);
        bus_write(IDX_MODE, 8'h01);
        check("irq masked", 0, timer_irq);
        bus_write(IDX_MODE, 8'h00);
        pins.count_edges(3);
        expect_reg("counted edges", IDX_CNT_LOW, 8'hC6);
        bus_write(IDX_CONTROL, 8'h07);
        pins.trigger_fall();
        expect_reg("ignored trigger", IDX_CAP_LOW, 8'hC3);
        expect_reg("no external flag", IDX_CONTROL, 8'h07);
    endtask

    task automatic t_reload_trigger();
        bus_write(IDX_CAP_LOW, 8'h21);
        bus_write(IDX_CAP_HIGH, 8'h43);
        bus_write(IDX_CONTROL, 8'h0E);
        pins.trigger_fall();
        expect_reg("trigger reload low", IDX_CNT_LOW, 8'h21);
        expect_reg("trigger reload high", IDX_CNT_HIGH, 8'h43);
        expect_reg("reload flag", IDX_CONTROL, 8'h4E);
        bus_write(IDX_CONTROL, 8'h00);
    endtask

    task automatic t_baud();
        bus_write(IDX_CAP_LOW, 8'hF0);
        bus_write(IDX_CAP_HIGH, 8'hFF);
        bus_write(IDX_CNT_LOW, 8'hF0);
        bus_write(IDX_CNT_HIGH, 8'hFF);
        bus_write(IDX_CONTROL, 8'h35);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (serial_rx_clock !== 1'b1 && n < 100);
        end
        check("reload period", 32, n);
        check("tx pulse", 1, serial_tx_clock);
        bus_write(IDX_CONTROL, 8'h31);
        expect_reg("no overflow flag", IDX_CONTROL, 8'h31);
        check("no irq", 0, timer_irq);
        bus_write(IDX_CONTROL, 8'h00);
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end

    // Main sequence
    initial begin
        mismatches = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h1;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_reset_values();
        t_timer_overflow();
        t_capture();
        t_reload_trigger();
        t_baud();
        end_of_test();
    end
endmodule
